// ### inc/gpio_bank_pkg.sv
package gpio_bank_pkg;
  localparam int unsigned CHANNELS = 8;
  localparam int unsigned LINES    = 64;
  localparam int unsigned ADDR_W   = 8;

  // Byte offsets on the register bus
  localparam logic [7:0] CFG_BASE  = 8'h00;
  localparam logic [7:0] DATA_BASE = 8'h20;
  localparam logic [7:0] MEAS_BASE = 8'h40;
  localparam logic [7:0] BSEL_OFF  = 8'h60;
  localparam logic [7:0] BVAL_OFF  = 8'h64;
  localparam logic [7:0] BANK_OFF  = 8'h68;
  localparam logic [7:0] BLOCK_MSK = 8'hE0;
  localparam logic [7:0] WORD_MSK  = 8'hFC;

  // Channel configuration fields
  localparam int unsigned CFG_WIDTH_LSB = 0;
  localparam int unsigned CFG_POL_BIT   = 2;
  localparam int unsigned CFG_DRIVE_BIT = 3;
  localparam int unsigned CFG_DIR_BIT   = 4;

  // Bit select fields
  localparam int unsigned BSEL_CH_LSB  = 0;
  localparam int unsigned BSEL_IDX_LSB = 8;

  // Bank status fields
  localparam int unsigned BANK0_LSB = 0;
  localparam int unsigned BANK1_LSB = 8;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    byte_width        = 2'h0,
    word_width        = 2'h1,
    double_word_width = 2'h3
  } width_e;

  typedef enum logic {polarity_normal = 1'b0, polarity_inverted = 1'b1} pol_e;
  typedef enum logic {active_drive = 1'b0, open_drain_drive = 1'b1} drive_e;

  typedef enum logic [2:0] {
    reg_cfg, reg_data, reg_meas, reg_bsel, reg_bval, reg_bank, reg_none
  } reg_e;

  typedef struct packed {
    logic   dir_out;
    drive_e drive;
    pol_e   pol;
    width_e width;
  } chan_cfg_s;

  localparam chan_cfg_s CFG_RESET = '{dir_out: 1'b0, drive: active_drive,
                                      pol: polarity_normal, width: byte_width};
endpackage : gpio_bank_pkg

// ### rtl/gpio_banks.sv
`timescale 1ns/10ps
// Summary of operation
// - 64 lines, eight byte channels, two banks
// - Byte, word and double-word channel widths
// - Only first/third channel may lead groups
// - Bank transfer mode follows first channel
// - Measure read forces leader to input, restores its defaults
// - Channel read returns value at width
// - Single bit read, index bounded by width
// - Sense keeps direction, output returns written data
// - Width and polarity apply both directions
// - Active drive drives high and low
// - Open drain pulls low, else releases
// - Data write turns group to output
// - Written data masked to channel width
// - Leader sets direction of whole group
// - Each slice keeps own polarity, drive
module gpio_banks (
  input  wire logic                             mclk,
  input  wire logic                             reset,
  input  wire logic [gpio_bank_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                             s_axi_awvalid,
  output logic                                  s_axi_awready,
  input  wire logic [31:0]                      s_axi_wdata,
  input  wire logic [3:0]                       s_axi_wstrb,
  input  wire logic                             s_axi_wvalid,
  output logic                                  s_axi_wready,
  output logic [1:0]                            s_axi_bresp,
  output logic                                  s_axi_bvalid,
  input  wire logic                             s_axi_bready,
  input  wire logic [gpio_bank_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                             s_axi_arvalid,
  output logic                                  s_axi_arready,
  output logic [31:0]                           s_axi_rdata,
  output logic [1:0]                            s_axi_rresp,
  output logic                                  s_axi_rvalid,
  input  wire logic                             s_axi_rready,
  input  wire logic [gpio_bank_pkg::LINES-1:0]  gpio_in,
  output logic [gpio_bank_pkg::LINES-1:0]       gpio_out,
  output logic [gpio_bank_pkg::LINES-1:0]       gpio_oe
);
  import gpio_bank_pkg::*;

  chan_cfg_s  cfg [CHANNELS];
  logic [7:0] out_data [CHANNELS];
  logic [2:0] sel_ch;
  logic [4:0] sel_idx;
  logic       wr_fire;
  logic       rd_fire;
  reg_e       wr_reg;
  reg_e       rd_reg;
  logic [2:0] wr_ch;
  logic [2:0] rd_ch;
  logic [31:0] wr_mask, bit_mask, bit_group;

  function automatic reg_e decode(input logic [7:0] a);
    if ((a & BLOCK_MSK) == CFG_BASE) decode = reg_cfg;
    else if ((a & BLOCK_MSK) == DATA_BASE) decode = reg_data;
    else if ((a & BLOCK_MSK) == MEAS_BASE) decode = reg_meas;
    else if ((a & WORD_MSK) == BSEL_OFF) decode = reg_bsel;
    else if ((a & WORD_MSK) == BVAL_OFF) decode = reg_bval;
    else if ((a & WORD_MSK) == BANK_OFF) decode = reg_bank;
    else decode = reg_none;
  endfunction : decode

  // Group leader: double word on first channel beats word pairs
  function automatic logic [2:0] lead(input logic [2:0] c);
    logic [2:0] first;
    logic [2:0] base;
    first = {c[2], 2'b00};
    base  = {c[2], c[1], 1'b0};
    if (cfg[first].width == double_word_width) lead = first;
    else if (cfg[base].width == word_width) lead = base;
    else lead = c;
  endfunction : lead

  function automatic logic [31:0] wmask(input width_e w);
    case (w)
      double_word_width: wmask = 32'hFFFFFFFF;
      word_width:        wmask = 32'h0000FFFF;
      default:           wmask = 32'h000000FF;
    endcase
  endfunction : wmask

  // Own polarity per slice; outputs read back the written data, not the pin level
  function automatic logic [7:0] chan_val(input logic [2:0] j);
    if (cfg[lead(j)].dir_out) chan_val = out_data[j];
    else chan_val = gpio_in[{j, 3'b000} +: 8] ^ {8{cfg[j].pol}};
  endfunction : chan_val

  function automatic logic [31:0] group_val(input logic [2:0] l);
    logic [31:0] v;
    v = 32'h00000000;
    for (int k = 0; k < 4; k++) begin
      v[8*k +: 8] = chan_val(l + 3'(k));
    end
    group_val = v & wmask(cfg[l].width);
  endfunction : group_val

  // Width requests outside the leader positions are ignored
  function automatic logic width_ok(input logic [2:0] c, input width_e w);
    case (w)
      double_word_width: width_ok = (c[1:0] == 2'b00);
      word_width:        width_ok = (c[0] == 1'b0);
      default:           width_ok = (w == byte_width);
    endcase
  endfunction : width_ok

  assign wr_reg  = decode(s_axi_awaddr);
  assign rd_reg  = decode(s_axi_araddr);
  assign wr_ch   = s_axi_awaddr[4:2];
  assign rd_ch   = s_axi_araddr[4:2];
  // Address and data are taken together; the master holds both
  assign s_axi_awready = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  assign s_axi_wready  = s_axi_awready;
  assign s_axi_arready = ~s_axi_rvalid;
  assign wr_fire = s_axi_awready;
  assign rd_fire = s_axi_arvalid & s_axi_arready;
  always_comb begin
    wr_mask   = wmask(cfg[lead(wr_ch)].width);
    bit_mask  = wmask(cfg[lead(sel_ch)].width);
    bit_group = group_val(lead(sel_ch));
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      for (int j = 0; j < CHANNELS; j++) cfg[j] <= CFG_RESET;
    end else begin
      if (wr_fire && wr_reg == reg_cfg && s_axi_wstrb[0]) begin
        cfg[wr_ch].pol   <= pol_e'(s_axi_wdata[CFG_POL_BIT]);
        cfg[wr_ch].drive <= drive_e'(s_axi_wdata[CFG_DRIVE_BIT]);
        if (width_ok(wr_ch, width_e'(s_axi_wdata[CFG_WIDTH_LSB +: 2])))
          cfg[wr_ch].width <= width_e'(s_axi_wdata[CFG_WIDTH_LSB +: 2]);
        for (int j = 0; j < CHANNELS; j++) begin
          if (3'(j) == wr_ch || lead(3'(j)) == wr_ch)
            cfg[j].dir_out <= s_axi_wdata[CFG_DIR_BIT];
        end
      end
      if (wr_fire && wr_reg == reg_data) begin
        for (int j = 0; j < CHANNELS; j++) begin
          if (lead(3'(j)) == lead(wr_ch)) cfg[j].dir_out <= 1'b1;
        end
      end
      if (rd_fire && rd_reg == reg_meas)
        cfg[lead(rd_ch)] <= CFG_RESET;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      for (int j = 0; j < CHANNELS; j++) out_data[j] <= 8'h00;
    end else if (wr_fire && wr_reg == reg_data) begin
      for (int k = 0; k < 4; k++) begin
        if (wr_mask[8*k] && s_axi_wstrb[k])
          out_data[lead(wr_ch) + 3'(k)] <= s_axi_wdata[8*k +: 8];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      sel_ch  <= 3'h0;
      sel_idx <= 5'h00;
    end else if (wr_fire && wr_reg == reg_bsel && s_axi_wstrb != 4'h0) begin
      sel_ch  <= s_axi_wdata[BSEL_CH_LSB +: 3];
      sel_idx <= s_axi_wdata[BSEL_IDX_LSB +: 5];
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wr_reg == reg_none || wr_reg == reg_meas ||
                       wr_reg == reg_bval || wr_reg == reg_bank)
                      ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      s_axi_rdata  <= 32'h00000000;
      if (rd_reg == reg_cfg) begin
        s_axi_rdata <= {27'h0000000, cfg[rd_ch]};
      end else if (rd_reg == reg_data) begin
        s_axi_rdata <= group_val(lead(rd_ch));
      end else if (rd_reg == reg_meas) begin
        // Defaults apply: byte wide, normal polarity
        s_axi_rdata <= {24'h000000, gpio_in[{lead(rd_ch), 3'b000} +: 8]};
      end else if (rd_reg == reg_bsel) begin
        s_axi_rdata <= {19'h00000, sel_idx, 5'h00, sel_ch};
      end else if (rd_reg == reg_bval) begin
        if (bit_mask[sel_idx])
          s_axi_rdata <= {31'h00000000, bit_group[sel_idx]};
        else
          s_axi_rresp <= RESP_SLVERR;
      end else if (rd_reg == reg_bank) begin
        s_axi_rdata[BANK0_LSB +: 3] <= {cfg[0].dir_out, cfg[0].width};
        s_axi_rdata[BANK1_LSB +: 3] <= {cfg[4].dir_out, cfg[4].width};
      end else begin
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Pins registered; one cycle behind configuration and data
  always_ff @(posedge mclk) begin
    if (reset) begin
      gpio_out <= '0;
      gpio_oe  <= '0;
    end else begin
      for (int j = 0; j < CHANNELS; j++) begin
        if (cfg[j].drive == open_drain_drive) begin
          gpio_out[8*j +: 8] <= 8'h00;
          gpio_oe[8*j +: 8]  <= {8{cfg[lead(3'(j))].dir_out}} &
                                ~(out_data[j] ^ {8{cfg[j].pol}});
        end else begin
          gpio_out[8*j +: 8] <= out_data[j] ^ {8{cfg[j].pol}};
          gpio_oe[8*j +: 8]  <= {8{cfg[lead(3'(j))].dir_out}};
        end
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  reset_defaults_a: assert property ($fell(reset) |-> cfg[3] == CFG_RESET)
    else $error("channel not at defaults after reset");
  write_output_a: assert property (wr_fire && wr_reg == reg_data && wr_ch == 3'h0
      |=> cfg[0].dir_out ##1 gpio_oe[0] || cfg[0].drive == open_drain_drive)
    else $error("data write did not set output");
  byte_mask_a: assert property (wr_fire && wr_reg == reg_data &&
      wr_ch == 3'h1 && lead(3'h1) == 3'h1 && s_axi_wstrb[0] |=>
    out_data[1] == $past(s_axi_wdata[7:0]) && $stable(out_data[2]))
    else $error("byte write not masked");
  meas_input_a: assert property (rd_fire && rd_reg == reg_meas && rd_ch == 3'h5
      && lead(3'h5) == 3'h5 |=> cfg[5] == CFG_RESET)
    else $error("measure did not restore defaults");
  read_answer_a: assert property (rd_fire |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  open_drain_a: assert property (cfg[3].drive == open_drain_drive
      |=> gpio_out[31:24] == 8'h00)
    else $error("open drain drives high");
  active_oe_a: assert property (cfg[0].drive == active_drive && cfg[0].dir_out
      |=> gpio_oe[7:0] == 8'hFF)
    else $error("active output not enabled");
  bit_range_a: assert property (rd_fire && rd_reg == reg_bval &&
      cfg[lead(sel_ch)].width != double_word_width &&
      sel_idx > (cfg[lead(sel_ch)].width == word_width ? 5'd15 : 5'd7)
      |=> s_axi_rresp == RESP_SLVERR)
    else $error("bit index beyond width accepted");
  group_dir_a: assert property (cfg[0].width == word_width &&
      cfg[0].drive == active_drive && cfg[1].drive == active_drive
      |=> gpio_oe[8] == gpio_oe[0])
    else $error("member direction differs from leader");
  leader_pos_a: assert property (cfg[1].width == byte_width &&
      cfg[3].width == byte_width && cfg[2].width != double_word_width)
    else $error("width on a non-leader channel");
  invert_in_a: assert property (!cfg[lead(3'h1)].dir_out && cfg[1].pol ==
      polarity_inverted |-> chan_val(3'h1) == ~gpio_in[15:8])
    else $error("inverted input not complemented");

  dword_write_c: cover property (wr_fire && wr_reg == reg_data &&
      cfg[4].width == double_word_width);
  meas_read_c: cover property (rd_fire && rd_reg == reg_meas);
  bit_error_c: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
  open_drain_c: cover property (cfg[2].drive == open_drain_drive &&
      cfg[2].dir_out);
endmodule : gpio_banks

// ### verification/gpio_line_model.sv
`timescale 1ns/10ps
module gpio_line_model (
  input  wire logic [gpio_bank_pkg::LINES-1:0] gpio_out,
  input  wire logic [gpio_bank_pkg::LINES-1:0] gpio_oe,
  input  wire logic [gpio_bank_pkg::LINES-1:0] ext_val,
  input  wire logic                            ext_en,
  output logic      [gpio_bank_pkg::LINES-1:0] gpio_in
);
  import gpio_bank_pkg::*;
  // Released lines take ext_val, or sit on the pull-up when ext_en is low, so a stale level never shows
  always_comb begin
    for (int i = 0; i < LINES; i++) begin
      gpio_in[i] = gpio_oe[i] ? gpio_out[i] : (ext_en ? ext_val[i] : 1'b1);
    end
  end
endmodule : gpio_line_model

// ### verification/grouped_digital_io_banks_bench.sv
`timescale 1ns/10ps
module grouped_digital_io_banks_bench;
  import gpio_bank_pkg::*;
  logic        mclk, reset, ext_en;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [63:0] gpio_in, gpio_out, gpio_oe, ext_val;
  int          failures, n_tests;

  gpio_banks uut (.mclk, .reset, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .gpio_in, .gpio_out, .gpio_oe);
  gpio_line_model lines (.gpio_out, .gpio_oe, .ext_val, .ext_en, .gpio_in);

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      failures++;
    end
  endtask : chk

  // Both channels offered at once, response ready held from the start
  task automatic wr(logic [7:0] a, logic [31:0] v);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin @(posedge mclk); n++; end while (s_axi_awready !== 1'b1 && n < 50);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do begin @(posedge mclk); n++; end while (s_axi_bvalid !== 1'b1 && n < 50);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= 50) begin failures++; report_and_stop(); end
  endtask : wr

  task automatic rd(logic [7:0] a);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin @(posedge mclk); n++; end while (s_axi_arready !== 1'b1 && n < 50);
    s_axi_arvalid <= 1'b0;
    do begin @(posedge mclk); n++; end while (s_axi_rvalid !== 1'b1 && n < 50);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 50) begin failures++; report_and_stop(); end
  endtask : rd

  // Pins follow one cycle after the register, so let two edges pass
  task automatic pins(int ch, logic [7:0] eo, logic [7:0] ee);
    repeat (2) @(posedge mclk);
    #1;
    chk("pin drive", {24'h0, eo}, {24'h0, gpio_out[8*ch+:8]});
    chk("pin enable", {24'h0, ee}, {24'h0, gpio_oe[8*ch+:8]});
    @(posedge mclk);
  endtask : pins

  task automatic t_reset();
    rd(CFG_BASE); chk("cfg after reset", 32'h0, d);
    pins(0, 8'h00, 8'h00);
    $display("test reset done");
  endtask : t_reset

  task automatic t_measure();
    ext_val[47:40] <= 8'h3C;
    wr(CFG_BASE + 8'h14, 32'h0000_0004);
    chk("cfg write resp", {30'h0, RESP_OKAY}, {30'h0, r});
    rd(DATA_BASE + 8'h14); chk("inverted read", 32'hC3, d);
    rd(MEAS_BASE + 8'h14); chk("measure", 32'h3C, d);
    rd(CFG_BASE + 8'h14); chk("cfg after measure", 32'h0, d);
    wr(MEAS_BASE + 8'h14, 32'h0000_00FF);
    chk("meas write resp", {30'h0, RESP_SLVERR}, {30'h0, r});
    $display("test measure done");
  endtask : t_measure

  task automatic t_write_mask();
    wr(DATA_BASE + 8'h08, 32'h0000_FFFB);
    pins(2, 8'hFB, 8'hFF);
    rd(CFG_BASE + 8'h08); chk("dir set", 32'h10, d);
    rd(DATA_BASE + 8'h08); chk("driven value", 32'hFB, d);
    wr(DATA_BASE + 8'h04, 32'h0000_ABCD);
    rd(DATA_BASE + 8'h04); chk("byte lane", 32'hCD, d);
    rd(DATA_BASE + 8'h08); chk("neighbour kept", 32'hFB, d);
    $display("test write mask done");
  endtask : t_write_mask

  task automatic t_word();
    wr(CFG_BASE + 8'h04, 32'h0000_0004);
    wr(CFG_BASE, 32'h0000_0001);
    wr(DATA_BASE, 32'h1234_5678);
    pins(0, 8'h78, 8'hFF);
    pins(1, 8'hA9, 8'hFF);
    rd(DATA_BASE); chk("word read", 32'h5678, d);
    rd(DATA_BASE + 8'h04); chk("member read", 32'h5678, d);
    $display("test word done");
  endtask : t_word

  task automatic t_bit();
    wr(BSEL_OFF, 32'h0000_0300);
    rd(BVAL_OFF); chk("bit 3", 32'h1, d);
    wr(BSEL_OFF, 32'h0000_0E00);
    rd(BVAL_OFF); chk("bit 14", 32'h1, d);
    wr(BSEL_OFF, 32'h0000_1000);
    rd(BVAL_OFF); chk("bit 16 resp", {30'h0, RESP_SLVERR}, {30'h0, r});
    $display("test bit done");
  endtask : t_bit

  task automatic t_open_drain();
    wr(CFG_BASE + 8'h0C, 32'h0000_0008);
    wr(DATA_BASE + 8'h0C, 32'h0000_000F);
    pins(3, 8'h00, 8'hF0);
    rd(DATA_BASE + 8'h0C); chk("open drain read", 32'h0F, d);
    ext_en <= 1'b0;
    rd(MEAS_BASE + 8'h0C); chk("wired level", 32'h0F, d);
    ext_en <= 1'b1;
    $display("test open drain done");
  endtask : t_open_drain

  task automatic t_dword();
    ext_val[63:32] <= 32'hCAFE_1234;
    wr(CFG_BASE + 8'h10, 32'h0000_0003);
    rd(DATA_BASE + 8'h10); chk("dword read", 32'hCAFE_1234, d);
    rd(BANK_OFF); chk("bank mode", 32'h0305, d);
    wr(CFG_BASE + 8'h14, 32'h0000_0003);
    rd(CFG_BASE + 8'h14); chk("illegal leader", 32'h0, d);
    rd(8'h80); chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, r});
    $display("test dword done");
  endtask : t_dword

  initial begin
    failures = 0;
    n_tests = 0;
    ext_en = 1'b1;
    ext_val = 64'h0;
    reset = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    t_reset();
    t_measure();
    t_write_mask();
    t_word();
    t_bit();
    t_open_drain();
    t_dword();
    report_and_stop();
  end
endmodule : grouped_digital_io_banks_bench
